/* File: pkg/alrx_defines.vh */
// Constants shared by the receive path and its word store
`ifndef ALRX_DEFINES_VH
`define ALRX_DEFINES_VH

// ---------------------------------------------------------------------------
// Sampling
// ---------------------------------------------------------------------------
`define ALRX_SHR_W 10
`define ALRX_SHR_TOP 9
`define ALRX_UP_LSB 5
`define ALRX_LO_MSB 4
`define ALRX_LOW_DIV 3'h7
`define ALRX_NPINS 4

// ---------------------------------------------------------------------------
// Bit spacing and word gap, counted in samples
// ---------------------------------------------------------------------------
`define ALRX_SPACE_MIN 4'h8
`define ALRX_SPACE_MAX 4'hc
`define ALRX_SPACE_SAT 4'hf
`define ALRX_GAP_PERIOD 4'h9
`define ALRX_GAP_DONE 2'h3

// ---------------------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------------------
`define ALRX_WORD_W 32
`define ALRX_LAST_BIT 6'h1f
`define ALRX_PAR_BIT 31
`define ALRX_LABEL_MSB 7
`define ALRX_SDI_B10 9
`define ALRX_SDI_B9 8
`define ALRX_LABEL_N 256

// ---------------------------------------------------------------------------
// Word store
// ---------------------------------------------------------------------------
`define ALRX_FIFO_AW 5
`define ALRX_FIFO_DEPTH 6'h20
`define ALRX_FIFO_HALF 6'h10
`define ALRX_FIFO_CW 6

`endif

/* File: verilog/alrx_fifo_mem.v */
// Word store of the receive queue, registered read port
`timescale 1ns/100ps
`include "alrx_defines.vh"

module alrx_fifo_mem (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [`ALRX_FIFO_AW-1:0] wr_addr,
  input wire [`ALRX_WORD_W-1:0] wr_data,
  input wire rd_en,
  input wire [`ALRX_FIFO_AW-1:0] rd_addr,
  output reg [`ALRX_WORD_W-1:0] rd_data_ff
);

  // -------------------------------------------------------------------------
  // Storage
  // -------------------------------------------------------------------------
  // No reset on the array; emptiness is tracked by the receiver's word count alone
  reg [`ALRX_WORD_W-1:0] mem [0:(1<<`ALRX_FIFO_AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data holds until the next read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= {`ALRX_WORD_W{1'b0}};
    end else if (rd_en) begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule

/* File: verilog/alrx_receiver.v */
// Line sampling, word framing, acceptance filter and receive queue
`timescale 1ns/100ps
`include "alrx_defines.vh"

module alrx_receiver (
  input wire clk,
  input wire rst_n,
  input wire aclk,
  input wire line_one_in,
  input wire line_zero_in,
  input wire master_reset_pin,
  input wire rate_select,
  input wire label_filter_enable,
  input wire parity_check_enable,
  input wire receiver_enable_bit,
  input wire decoder_check_enable,
  input wire match_bit10,
  input wire match_bit9,
  input wire flag_pin_select,
  input wire rd_req,
  input wire tbl_wr_en,
  input wire [`ALRX_LABEL_MSB:0] tbl_wr_addr,
  input wire tbl_wr_data,
  input wire [`ALRX_LABEL_MSB:0] tbl_rd_addr,
  output wire [`ALRX_WORD_W-1:0] rd_data,
  output reg rd_valid_ff,
  output reg fifo_empty_flag,
  output reg fifo_half_full_flag,
  output reg fifo_full_flag,
  output reg fifo_flag_pin,
  output reg data_ready_ff,
  output reg tbl_rd_data_ff
);

  localparam [1:0] ST_GAP = 2'b00;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RX = 2'b10;

  // Any run of three consecutive high samples in a half register
  function has_run3;
    input [`ALRX_LO_MSB:0] v;
    begin
      has_run3 = |(v[4:2] & v[3:1] & v[2:0]);
    end
  endfunction

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  wire [`ALRX_NPINS-1:0] pin_raw;
  reg [`ALRX_NPINS-1:0] sync1_ff;
  reg [`ALRX_NPINS-1:0] sync2_ff;
  assign pin_raw = {master_reset_pin, aclk, line_zero_in, line_one_in};

  genvar gi;
  generate
    for (gi = 0; gi < `ALRX_NPINS; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  wire one_s = sync2_ff[0];
  wire zero_s = sync2_ff[1];
  wire aclk_s = sync2_ff[2];
  wire mr_s = sync2_ff[3];

  // -------------------------------------------------------------------------
  // Sample timing
  // -------------------------------------------------------------------------
  // The system clock must run well above twice the ARINC clock
  reg aclk_d_ff;
  reg [2:0] div_ff;
  wire aclk_rise = aclk_s & ~aclk_d_ff;
  wire sample_tick = aclk_rise &
                     (~rate_select | (div_ff == `ALRX_LOW_DIV));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aclk_d_ff <= 1'b0;
      div_ff <= 3'h0;
    end else begin
      aclk_d_ff <= aclk_s;
      if (aclk_rise) begin
        div_ff <= div_ff + 3'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Sampling shift registers
  // -------------------------------------------------------------------------
  // Both comparators high is treated as between bands: all shift low
  wire band_one = one_s & ~zero_s;
  wire band_zero = zero_s & ~one_s;
  wire band_null = ~one_s & ~zero_s;
  reg [`ALRX_SHR_TOP:0] one_ff;
  reg [`ALRX_SHR_TOP:0] zero_ff;
  reg [`ALRX_SHR_TOP:0] null_ff;
  reg bit_prev_ff;
  wire [`ALRX_SHR_TOP:0] nxt_one = {one_ff[`ALRX_SHR_TOP-1:0], band_one};
  wire [`ALRX_SHR_TOP:0] nxt_zero = {zero_ff[`ALRX_SHR_TOP-1:0], band_zero};
  wire [`ALRX_SHR_TOP:0] nxt_null = {null_ff[`ALRX_SHR_TOP-1:0], band_null};
  wire null_lo = has_run3(nxt_null[`ALRX_LO_MSB:0]);
  wire bit_one_c = has_run3(nxt_one[`ALRX_SHR_TOP:`ALRX_UP_LSB]) &
                   null_lo;
  wire bit_zero_c = has_run3(nxt_zero[`ALRX_SHR_TOP:`ALRX_UP_LSB]) &
                    null_lo;
  wire bit_c = bit_one_c | bit_zero_c;
  wire gap_null_c = has_run3(nxt_null[`ALRX_SHR_TOP:`ALRX_UP_LSB]) &
                    null_lo;
  // Only the first sample that completes the pattern counts as the bit
  wire bit_det = sample_tick & bit_c & ~bit_prev_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      one_ff <= {`ALRX_SHR_W{1'b0}};
      zero_ff <= {`ALRX_SHR_W{1'b0}};
      null_ff <= {`ALRX_SHR_W{1'b0}};
      bit_prev_ff <= 1'b0;
    end else if (sample_tick) begin
      one_ff <= nxt_one;
      zero_ff <= nxt_zero;
      null_ff <= nxt_null;
      bit_prev_ff <= bit_c;
    end
  end

  // -------------------------------------------------------------------------
  // Word framing
  // -------------------------------------------------------------------------
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] sp_ff;
  reg [3:0] nxt_sp;
  reg [3:0] gt_ff;
  reg [3:0] nxt_gt;
  reg [1:0] gap_cnt_ff;
  reg [1:0] nxt_gap_cnt;
  reg [5:0] bitcnt_ff;
  reg [5:0] nxt_bitcnt;
  reg par_ff;
  reg nxt_par;
  reg [`ALRX_WORD_W-1:0] word_ff;
  reg [`ALRX_WORD_W-1:0] nxt_word;
  reg [`ALRX_WORD_W-1:0] done_ff;
  reg [`ALRX_WORD_W-1:0] nxt_done;
  reg eos_ff;
  reg nxt_eos;
  wire [3:0] sp_inc = (sp_ff == `ALRX_SPACE_SAT) ? sp_ff : sp_ff + 4'h1;
  wire space_ok = (sp_inc >= `ALRX_SPACE_MIN) &&
                  (sp_inc <= `ALRX_SPACE_MAX);
  wire [`ALRX_WORD_W-1:0] shifted = {bit_one_c, word_ff[`ALRX_WORD_W-1:1]};
  wire par_new = par_ff ^ bit_one_c;

  always @* begin
    nxt_state = state_ff;
    nxt_sp = sp_ff;
    nxt_gt = gt_ff;
    nxt_gap_cnt = gap_cnt_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_par = par_ff;
    nxt_word = word_ff;
    nxt_done = done_ff;
    nxt_eos = 1'b0;
    case (state_ff)
      ST_GAP: begin
        if (sample_tick) begin
          if (gt_ff == `ALRX_GAP_PERIOD) begin
            nxt_gt = 4'h0;
            if (gap_null_c) begin
              nxt_gap_cnt = gap_cnt_ff + 2'h1;
              if (nxt_gap_cnt == `ALRX_GAP_DONE) begin
                nxt_state = ST_IDLE;
                nxt_gap_cnt = 2'h0;
              end
            end else begin
              nxt_gap_cnt = 2'h0;
            end
          end else begin
            nxt_gt = gt_ff + 4'h1;
          end
        end
      end
      ST_IDLE: begin
        if (bit_det) begin
          nxt_state = ST_RX;
          nxt_word = shifted;
          nxt_par = bit_one_c;
          nxt_bitcnt = 6'h1;
          nxt_sp = 4'h0;
        end
      end
      ST_RX: begin
        if (bit_det) begin
          if (space_ok) begin
            nxt_word = shifted;
            nxt_par = par_new;
            nxt_bitcnt = bitcnt_ff + 6'h1;
            nxt_sp = 4'h0;
            if (bitcnt_ff == `ALRX_LAST_BIT) begin
              nxt_eos = 1'b1;
              nxt_done = shifted;
              if (parity_check_enable & par_new) begin
                nxt_done[`ALRX_PAR_BIT] = 1'b0;
              end
              nxt_state = ST_GAP;
              nxt_gt = 4'h0;
              nxt_gap_cnt = 2'h0;
            end
          end else begin
            nxt_state = ST_GAP;
            nxt_gt = 4'h0;
            nxt_gap_cnt = 2'h0;
          end
        end else if (sample_tick) begin
          nxt_sp = sp_inc;
          if (sp_inc > `ALRX_SPACE_MAX) begin
            nxt_state = ST_GAP;
            nxt_gt = 4'h0;
            nxt_gap_cnt = 2'h0;
          end
        end
      end
      default: begin
        nxt_state = ST_GAP;
      end
    endcase
    if (mr_s | ~receiver_enable_bit) begin
      nxt_state = ST_GAP;
      nxt_gt = 4'h0;
      nxt_gap_cnt = 2'h0;
      nxt_bitcnt = 6'h0;
      nxt_eos = 1'b0;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_GAP;
      sp_ff <= 4'h0;
      gt_ff <= 4'h0;
      gap_cnt_ff <= 2'h0;
      bitcnt_ff <= 6'h0;
      par_ff <= 1'b0;
      word_ff <= {`ALRX_WORD_W{1'b0}};
      done_ff <= {`ALRX_WORD_W{1'b0}};
      eos_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sp_ff <= nxt_sp;
      gt_ff <= nxt_gt;
      gap_cnt_ff <= nxt_gap_cnt;
      bitcnt_ff <= nxt_bitcnt;
      par_ff <= nxt_par;
      word_ff <= nxt_word;
      done_ff <= nxt_done;
      eos_ff <= nxt_eos;
    end
  end

  // -------------------------------------------------------------------------
  // Label table and acceptance
  // -------------------------------------------------------------------------
  // Not touched by master reset, like the control bits
  reg [`ALRX_LABEL_N-1:0] label_tbl_ff;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      label_tbl_ff <= {`ALRX_LABEL_N{1'b0}};
      tbl_rd_data_ff <= 1'b0;
    end else begin
      if (tbl_wr_en) begin
        label_tbl_ff[tbl_wr_addr] <= tbl_wr_data;
      end
      tbl_rd_data_ff <= label_tbl_ff[tbl_rd_addr];
    end
  end

  wire lbl_ok = ~label_filter_enable |
                label_tbl_ff[done_ff[`ALRX_LABEL_MSB:0]];
  wire dec_ok = ~decoder_check_enable |
                ((done_ff[`ALRX_SDI_B10] == match_bit10) &
                 (done_ff[`ALRX_SDI_B9] == match_bit9));
  // Dropped words never reach the queue or the flags
  wire load = eos_ff & lbl_ok & dec_ok & ~mr_s;

  // -------------------------------------------------------------------------
  // Receive queue
  // -------------------------------------------------------------------------
  reg [`ALRX_FIFO_AW-1:0] wr_ptr_ff;
  reg [`ALRX_FIFO_AW-1:0] rd_ptr_ff;
  reg [`ALRX_FIFO_CW-1:0] cnt_ff;
  reg [`ALRX_FIFO_CW-1:0] nxt_cnt;
  wire is_full = (cnt_ff == `ALRX_FIFO_DEPTH);
  wire rd_take = rd_req & (cnt_ff != {`ALRX_FIFO_CW{1'b0}}) & ~mr_s;
  // A full queue with no read in the same cycle loses its newest word
  wire overwrite = load & is_full & ~rd_take;
  wire [`ALRX_FIFO_AW-1:0] wr_addr = overwrite ?
       wr_ptr_ff - {{(`ALRX_FIFO_AW-1){1'b0}}, 1'b1} : wr_ptr_ff;
  wire nxt_empty = (nxt_cnt == {`ALRX_FIFO_CW{1'b0}});
  wire nxt_full = (nxt_cnt == `ALRX_FIFO_DEPTH);

  always @* begin
    nxt_cnt = cnt_ff;
    if (mr_s) begin
      nxt_cnt = {`ALRX_FIFO_CW{1'b0}};
    end else if (load & ~overwrite & ~rd_take) begin
      nxt_cnt = cnt_ff + {{(`ALRX_FIFO_CW-1){1'b0}}, 1'b1};
    end else if (rd_take & ~load) begin
      nxt_cnt = cnt_ff - {{(`ALRX_FIFO_CW-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= {`ALRX_FIFO_AW{1'b0}};
      rd_ptr_ff <= {`ALRX_FIFO_AW{1'b0}};
      cnt_ff <= {`ALRX_FIFO_CW{1'b0}};
      rd_valid_ff <= 1'b0;
      fifo_empty_flag <= 1'b1;
      fifo_half_full_flag <= 1'b0;
      fifo_full_flag <= 1'b0;
      fifo_flag_pin <= 1'b0;
      data_ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      rd_valid_ff <= rd_take;
      if (mr_s) begin
        wr_ptr_ff <= {`ALRX_FIFO_AW{1'b0}};
        rd_ptr_ff <= {`ALRX_FIFO_AW{1'b0}};
      end else begin
        if (load & ~overwrite) begin
          wr_ptr_ff <= wr_ptr_ff + {{(`ALRX_FIFO_AW-1){1'b0}}, 1'b1};
        end
        if (rd_take) begin
          rd_ptr_ff <= rd_ptr_ff + {{(`ALRX_FIFO_AW-1){1'b0}}, 1'b1};
        end
      end
      fifo_empty_flag <= nxt_empty;
      fifo_half_full_flag <= (nxt_cnt >= `ALRX_FIFO_HALF);
      fifo_full_flag <= nxt_full;
      fifo_flag_pin <= ~mr_s &
                       (flag_pin_select ? nxt_full : nxt_empty);
      // Set wins: a load always leaves the queue non-empty
      data_ready_ff <= ~mr_s & (load | (data_ready_ff & ~nxt_empty));
    end
  end

  alrx_fifo_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(load),
    .wr_addr(wr_addr),
    .wr_data(done_ff),
    .rd_en(rd_take),
    .rd_addr(rd_ptr_ff),
    .rd_data_ff(rd_data)
  );

endmodule

/* File: verif/alrx_chk_sva.sv */
// Port-level checks for the receive path
`timescale 1ns/100ps
module alrx_chk (
  input wire clk,
  input wire rst_n,
  input wire master_reset_pin,
  input wire flag_pin_select,
  input wire rd_req,
  input wire tbl_wr_en,
  input wire [7:0] tbl_wr_addr,
  input wire tbl_wr_data,
  input wire [7:0] tbl_rd_addr,
  input wire rd_valid_ff,
  input wire fifo_empty_flag,
  input wire fifo_half_full_flag,
  input wire fifo_full_flag,
  input wire fifo_flag_pin,
  input wire data_ready_ff,
  input wire tbl_rd_data_ff
);
  // ----------
  // Quiet time after master reset
  // ----------
  // Master reset crosses two sync stages, so flag relations wait it out
  logic [2:0] mr_q_ff;
  wire quiet = mr_q_ff == 3'h7;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mr_q_ff <= 3'h0;
    else if (master_reset_pin)
      mr_q_ff <= 3'h0;
    else if (!quiet)
      mr_q_ff <= mr_q_ff + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------
  // Assertions
  // ----------
  chk_half_empty: assert property (
    fifo_half_full_flag |-> !fifo_empty_flag) else $error("half and empty");
  chk_full_half: assert property (
    fifo_full_flag |-> fifo_half_full_flag) else $error("full not half");
  chk_ready_empty: assert property (
    data_ready_ff != fifo_empty_flag) else $error("ready vs empty");
  chk_rd_taken: assert property (
    rd_req && !fifo_empty_flag && quiet |=> rd_valid_ff)
    else $error("read not answered");
  chk_rd_idle: assert property (
    !rd_req |=> !rd_valid_ff) else $error("read without request");
  chk_full_hold: assert property (
    fifo_full_flag && !rd_req && quiet |=> fifo_full_flag)
    else $error("full dropped without read");
  chk_pin_follow: assert property (
    quiet && $stable(fifo_empty_flag) && $stable(fifo_full_flag) &&
    $stable(flag_pin_select) |-> fifo_flag_pin ==
    (flag_pin_select ? fifo_full_flag : fifo_empty_flag))
    else $error("flag pin wrong");
  chk_mr_clear: assert property (
    master_reset_pin [*5] |-> fifo_empty_flag && !fifo_half_full_flag &&
    !fifo_full_flag && !fifo_flag_pin && !data_ready_ff)
    else $error("master reset left state");
  chk_tbl_rdback: assert property (
    tbl_wr_en && tbl_wr_addr == tbl_rd_addr ##1
    !tbl_wr_en && $stable(tbl_rd_addr) |=>
    tbl_rd_data_ff == $past(tbl_wr_data, 2)) else $error("table readback");
endmodule

/* File: verif/alrx_line_tx.sv */
// Behavioural line transmitter with its timing clock
`timescale 1ns/100ps
module alrx_line_tx (
  output logic aclk,
  output logic line_one_in,
  output logic line_zero_in
);
  // Free-running, but 5 MHz so a full queue fits in the run
  initial aclk = 1'b0;
  always #100 aclk = ~aclk;
  initial begin
    line_one_in = 1'b0;
    line_zero_in = 1'b0;
  end
  // Hold one band for n timing clock periods
  task automatic seg(input logic o, input logic z, input int n);
    line_one_in = o;
    line_zero_in = z;
    repeat (n) @(negedge aclk);
  endtask
  // Bit 1 first, band then null per cell, word gap of nulls after
  task automatic send_word(input logic [31:0] w, input int sp,
                           input int m);
    for (int i = 0; i < 32; i++) begin
      seg(w[i], !w[i], sp / 2 * m);
      seg(1'b0, 1'b0, (sp - sp / 2) * m);
    end
    seg(1'b0, 1'b0, 40 * m);
  endtask
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the receive path
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) begin \
      mismatches++; \
      $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  logic clk, rst_n, aclk, line_one_in, line_zero_in, master_reset_pin;
  logic rate_select, label_filter_enable, parity_check_enable;
  logic receiver_enable_bit, decoder_check_enable, match_bit10;
  logic match_bit9, flag_pin_select, rd_req, tbl_wr_en, tbl_wr_data;
  logic [7:0] tbl_wr_addr, tbl_rd_addr;
  logic [31:0] rd_data, w;
  logic rd_valid_ff, fifo_empty_flag, fifo_half_full_flag, fifo_full_flag;
  logic fifo_flag_pin, data_ready_ff, tbl_rd_data_ff, ok;
  logic [255:0] tbl_sh;
  int mismatches = 0;
  int comparisons = 0;
  // Filter, decoder, match bits, parity; then the word
  logic [36:0] cs [0:10] = '{
    {5'h00, 32'h8000_0101}, {5'h01, 32'h8000_0101}, {5'h01, 32'h8000_0103},
    {5'h10, 32'h1234_563a}, {5'h10, 32'h1234_563b}, {5'h0c, 32'h0000_0200},
    {5'h0c, 32'h0000_0100}, {5'h1c, 32'h0000_023a}, {5'h1c, 32'h0000_013a},
    {5'h1c, 32'h0000_023b}, {5'h0a, 32'h0000_0100}};

  always #25 clk = ~clk;
  alrx_line_tx tx (.aclk, .line_one_in, .line_zero_in);
  alrx_receiver dut (.clk, .rst_n, .aclk, .line_one_in, .line_zero_in,
    .master_reset_pin, .rate_select, .label_filter_enable,
    .parity_check_enable, .receiver_enable_bit, .decoder_check_enable,
    .match_bit10, .match_bit9, .flag_pin_select, .rd_req, .tbl_wr_en,
    .tbl_wr_addr, .tbl_wr_data, .tbl_rd_addr, .rd_data, .rd_valid_ff,
    .fifo_empty_flag, .fifo_half_full_flag, .fifo_full_flag,
    .fifo_flag_pin, .data_ready_ff, .tbl_rd_data_ff);

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd_word(input logic [31:0] e);
    @(negedge clk) rd_req = 1'b1;
    @(negedge clk) rd_req = 1'b0;
    `CHK(rd_valid_ff, 1'b1)
    `CHK(rd_data, e)
  endtask
  task automatic tbl_wr(input logic [7:0] a, input logic d);
    @(negedge clk);
    tbl_wr_en = 1'b1;
    tbl_wr_addr = a;
    tbl_wr_data = d;
    tbl_rd_addr = a;
    tbl_sh[a] = d;
    @(negedge clk);
    tbl_wr_en = 1'b0;
    @(negedge clk);
    `CHK(tbl_rd_data_ff, d)
  endtask
  // Send one word, then check whether it landed and drain it
  task automatic rx(input logic [31:0] v, input logic ld, input int sp);
    tx.send_word(v, sp, rate_select ? 8 : 1);
    @(negedge clk);
    `CHK(fifo_empty_flag, !ld)
    `CHK(data_ready_ff, ld)
    `CHK(fifo_flag_pin, !ld)
    if (ld)
      rd_word(parity_check_enable && ^v ? {1'b0, v[30:0]} : v);
    `CHK(fifo_empty_flag, 1'b1)
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    {clk, rst_n, master_reset_pin, rate_select, label_filter_enable} = 5'h0;
    {parity_check_enable, decoder_check_enable, match_bit10} = 3'h0;
    {match_bit9, flag_pin_select, rd_req, tbl_wr_en, tbl_wr_data} = 5'h0;
    {tbl_wr_addr, tbl_rd_addr} = 16'h0;
    receiver_enable_bit = 1'b1;
    tbl_sh = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK({fifo_empty_flag, fifo_half_full_flag, fifo_full_flag}, 3'h4)
    `CHK(fifo_flag_pin, 1'b1)
    @(negedge clk) rd_req = 1'b1;
    @(negedge clk) rd_req = 1'b0;
    `CHK(rd_valid_ff, 1'b0)
    tbl_wr(8'h3a, 1'b1);
    tbl_wr(8'h3b, 1'b1);
    tbl_wr(8'h3b, 1'b0);
    tx.seg(1'b0, 1'b0, 40);
    foreach (cs[i]) begin
      @(negedge clk);
      {label_filter_enable, decoder_check_enable, match_bit10, match_bit9,
       parity_check_enable} = cs[i][36:32];
      w = cs[i][31:0];
      ok = (!label_filter_enable || tbl_sh[w[7:0]]) &&
           (!decoder_check_enable || w[9:8] == {match_bit10, match_bit9});
      rx(w, ok, 10);
    end
    {label_filter_enable, decoder_check_enable, parity_check_enable} = 3'h0;
    rx(32'h0000_00ff, 1'b0, 14);
    receiver_enable_bit = 1'b0;
    rx(32'h0000_00ff, 1'b0, 10);
    receiver_enable_bit = 1'b1;
    tx.seg(1'b0, 1'b0, 40);
    rx(32'h0000_00ff, 1'b1, 10);
    // ----------
    // Fill past full, then drain
    // ----------
    flag_pin_select = 1'b1;
    for (int i = 1; i <= 33; i++) begin
      tx.send_word(32'h5500_0000 | i, 10, 1);
      @(negedge clk);
      `CHK(fifo_half_full_flag, i >= 16)
      `CHK(fifo_full_flag, i >= 32)
      `CHK(fifo_flag_pin, i >= 32)
    end
    for (int i = 1; i <= 32; i++) begin
      rd_word(32'h5500_0000 | (i == 32 ? 33 : i));
      `CHK(fifo_half_full_flag, i <= 16)
    end
    `CHK(fifo_empty_flag, 1'b1)
    // ----------
    // Master reset in mid-word, then low speed
    // ----------
    flag_pin_select = 1'b0;
    tx.send_word(32'h0000_0011, 10, 1);
    fork
      tx.send_word(32'h0000_0022, 10, 1);
    join_none
    repeat (300) @(negedge clk);
    master_reset_pin = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({fifo_empty_flag, fifo_flag_pin, data_ready_ff}, 3'h4)
    master_reset_pin = 1'b0;
    wait fork;
    @(negedge clk);
    `CHK(fifo_empty_flag, 1'b1)
    rate_select = 1'b1;
    tx.seg(1'b0, 1'b0, 320);
    rx(32'h0000_0033, 1'b1, 10);
    give_verdict();
  end
endmodule

bind alrx_receiver alrx_chk u_chk (.clk, .rst_n, .master_reset_pin,
  .flag_pin_select, .rd_req, .tbl_wr_en, .tbl_wr_addr, .tbl_wr_data,
  .tbl_rd_addr, .rd_valid_ff, .fifo_empty_flag, .fifo_half_full_flag,
  .fifo_full_flag, .fifo_flag_pin, .data_ready_ff, .tbl_rd_data_ff);
